// ===== hw/anft_ctrl.sv
// Purpose: Asynchronous NOR flash access sequencer with programmable strobe timing.
// Assumes: ref_clk is the internal functional clock; pins are registered here.
// Notes: Half-cycle delays are made with falling-edge retimed copies of strobes.
`timescale 1ns/1ps
`include "anft_map.svh"
module anft_ctrl #(
	parameter int NUM_CS   = 8,
	parameter int NUM_WAIT = 2
) (
	input  wire logic                  ref_clk,      // Functional clock
	input  wire logic                  rst_n,        // Async reset, active low
	input  wire anft_pkg::anft_timing_t cfg,         // Timing set
	input  wire logic                  req_valid,    // Access request
	input  wire anft_pkg::anft_req_t   req,          // Request fields
	output logic                       req_ready,    // Idle, request taken
	output logic                       rdata_valid,  // Read word strobe
	output logic [15:0]                rdata,        // Sampled read word
	output logic                       done,         // Access finished pulse
	output logic [NUM_CS-1:0]          cs_n,         // Chip selects
	output logic                       addr_valid_n, // Address valid
	output logic                       oe_n,         // Output enable
	output logic                       we_n,         // Write strobe
	output logic [1:0]                 be_n,         // Byte enables
	output logic [25:0]                addr_out,     // Address pins
	output logic [15:0]                ad_out,       // Address/data out
	output logic                       ad_oe,        // Address/data drive
	input  wire logic [15:0]           ad_in,        // Address/data in
	input  wire logic [NUM_WAIT-1:0]   wait_in,      // Wait inputs
	output logic                       wait_sel      // Selected wait level
);
	// Scale a field by (scale + 1)
	function automatic logic [`ANFT_CW-1:0] scl(input logic [`ANFT_TW-1:0] t, input logic g);
		scl = g ? {3'h0, t, 1'b0} : {4'h0, t};
	endfunction

	// Extra page intervals for n words
	function automatic logic [`ANFT_CW-1:0] ext(input logic [`ANFT_TW-1:0] p,
		input logic [2:0] nm1, input logic g);
		ext = 10'(scl(p, g) * nm1);
	endfunction

	anft_pkg::anft_state_t state_q, state_d;
	anft_pkg::anft_req_t   req_q, req_d;
	logic [`ANFT_CW-1:0]   cnt_q, cnt_d;
	logic [`ANFT_CW-1:0]   pg_q, pg_d;
	logic [2:0]            wcnt_q, wcnt_d;
	logic                  cs_lvl, adv_lvl, oe_lvl, we_lvl, bus_drv, smp;
	logic [`ANFT_CW-1:0]   pburst, cs_off, adv_off, cyc_len;
	logic                  cs_q, adv_q, oe_q, we_q;
	logic                  cs_h_q, adv_h_q, oe_h_q, we_h_q;
	logic                  rv_q, rv_d, done_q, done_d, drv_q, dir_q;
	logic [15:0]           rd_q, rd_d, ad_q, ad_d;
	logic [25:0]           addr_q, addr_d;
	logic [1:0]            be_q, be_d;
	logic [NUM_CS-1:0]     csel_q;
	logic                  ws_q;

	// Strobe windows derived from the cycle counter
	always_comb
	begin
		pburst  = ext(cfg.page_word_interval, req_q.words_m1, cfg.timing_scale_bit);
		cs_off  = (req_q.write ? scl(cfg.chip_select_write_release, cfg.timing_scale_bit)
			: scl(cfg.chip_select_read_release, cfg.timing_scale_bit)) + pburst; // RL6
		adv_off = req_q.write ? scl(cfg.addr_valid_write_release, cfg.timing_scale_bit)
			: scl(cfg.addr_valid_read_release, cfg.timing_scale_bit);
		cyc_len = (req_q.write ? scl(cfg.write_cycle_length, cfg.timing_scale_bit)
			: scl(cfg.read_cycle_length, cfg.timing_scale_bit)) + pburst; // RL7
		cs_lvl  = (state_q == anft_pkg::ANFT_ACC)
			&& cnt_q >= scl(cfg.chip_select_assert_time, cfg.timing_scale_bit)
			&& cnt_q < cs_off; // RL5 RL8
		adv_lvl = (state_q == anft_pkg::ANFT_ACC)
			&& cnt_q >= scl(cfg.addr_valid_assert_time, cfg.timing_scale_bit)
			&& cnt_q < adv_off; // RL10
		oe_lvl  = (state_q == anft_pkg::ANFT_ACC) && !req_q.write
			&& cnt_q >= scl(cfg.output_enable_assert_time, cfg.timing_scale_bit)
			&& cnt_q < scl(cfg.output_enable_release_time, cfg.timing_scale_bit)
				+ pburst; // RL11 RL12
		we_lvl  = (state_q == anft_pkg::ANFT_ACC) && req_q.write
			&& cnt_q >= scl(cfg.write_strobe_assert_time, cfg.timing_scale_bit)
			&& cnt_q < scl(cfg.write_strobe_release_time, cfg.timing_scale_bit); // RL13
		// Writes drive all access; muxed reads drive only until output enable
		bus_drv = (state_q == anft_pkg::ANFT_ACC)
			&& (req_q.write || (cfg.muxed_mode
			&& cnt_q < scl(cfg.output_enable_assert_time, cfg.timing_scale_bit))); // RL14 RL16
		// No further sample once the last page word is taken
		smp     = (state_q == anft_pkg::ANFT_ACC) && !req_q.write
			&& wcnt_q <= req_q.words_m1
			&& (wcnt_q == `ANFT_WORD_ZERO
			? cnt_q == scl(cfg.data_sample_delay, cfg.timing_scale_bit) // RL1 RL2 RL21
			: cnt_q == pg_q); // RL3
	end

	// Sequencer next state
	always_comb
	begin
		state_d = state_q;
		req_d   = req_q;
		cnt_d   = cnt_q + `ANFT_CNT_ONE;
		pg_d    = pg_q;
		wcnt_d  = wcnt_q;
		rv_d    = smp;
		rd_d    = smp ? ad_in : rd_q;
		done_d  = 1'b0;
		addr_d  = addr_q;
		be_d    = be_q;
		ad_d    = ad_q;
		unique case (state_q)
			anft_pkg::ANFT_IDLE:
			begin
				cnt_d = `ANFT_CNT_ZERO;
				if (req_valid)
				begin
					state_d = anft_pkg::ANFT_ACC;
					req_d   = req;
					wcnt_d  = `ANFT_WORD_ZERO;
					addr_d  = req.addr; // RL9
					be_d    = req.byte_en_n; // RL9
					ad_d    = req.write ? req.wdata : req.addr[15:0]; // RL14
				end
			end
			anft_pkg::ANFT_ACC:
			begin
				if (smp)
				begin
					pg_d   = cnt_q + scl(cfg.page_word_interval, cfg.timing_scale_bit); // RL3
					wcnt_d = wcnt_q + `ANFT_WORD_ONE;
					if (wcnt_q != req_q.words_m1)
						addr_d = addr_q + 26'h1; // RL4
				end
				if (cnt_q + `ANFT_CNT_ONE >= cyc_len && cnt_q + `ANFT_CNT_ONE >= cs_off)
				begin
					state_d = anft_pkg::ANFT_GAP;
					cnt_d   = `ANFT_CNT_ZERO;
					done_d  = 1'b1;
					be_d    = `ANFT_BE_IDLE;
				end
			end
			anft_pkg::ANFT_GAP:
			begin
				if (cnt_q + `ANFT_CNT_ONE >= scl(cfg.inter_access_gap, cfg.timing_scale_bit))
					state_d = anft_pkg::ANFT_IDLE; // RL15
			end
			default:
				state_d = anft_pkg::ANFT_IDLE;
		endcase
	end

	// Sequencer registers
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_q <= anft_pkg::ANFT_IDLE;
			req_q   <= '0;
			cnt_q   <= `ANFT_CNT_ZERO;
			pg_q    <= `ANFT_CNT_ZERO;
			wcnt_q  <= `ANFT_WORD_ZERO;
			rv_q    <= 1'b0;
			rd_q    <= `ANFT_DATA_ZERO;
			done_q  <= 1'b0;
			addr_q  <= `ANFT_ADDR_ZERO;
			be_q    <= `ANFT_BE_IDLE;
			ad_q    <= `ANFT_DATA_ZERO;
		end
		else
		begin
			state_q <= state_d;
			req_q   <= req_d;
			cnt_q   <= cnt_d;
			pg_q    <= pg_d;
			wcnt_q  <= wcnt_d;
			rv_q    <= rv_d;
			rd_q    <= rd_d;
			done_q  <= done_d;
			addr_q  <= addr_d;
			be_q    <= be_d;
			ad_q    <= ad_d;
		end
	end

	// Strobe levels registered on the rising edge
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cs_q   <= 1'b0;
			adv_q  <= 1'b0;
			oe_q   <= 1'b0;
			we_q   <= 1'b0;
			drv_q  <= 1'b0;
			dir_q  <= 1'b0; // RL17
			csel_q <= `ANFT_CS_IDLE;
			ws_q   <= 1'b0;
		end
		else
		begin
			cs_q   <= cs_lvl;
			adv_q  <= adv_lvl;
			oe_q   <= oe_lvl;
			we_q   <= we_lvl;
			drv_q  <= bus_drv;
			dir_q  <= bus_drv; // RL17
			// Region mask held steady so a delayed release keeps its half cycle
			csel_q <= ~(NUM_CS'(1) << req_q.region); // RL19 RL8
			ws_q   <= wait_in[req_q.region[0]]; // RL19
		end
	end

	// Half-cycle retimed copies on the falling edge
	always_ff @(negedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cs_h_q  <= 1'b0;
			adv_h_q <= 1'b0;
			oe_h_q  <= 1'b0;
			we_h_q  <= 1'b0;
		end
		else
		begin
			cs_h_q  <= cs_q;
			adv_h_q <= adv_q;
			oe_h_q  <= oe_q;
			we_h_q  <= we_q;
		end
	end

	// Pin drivers pick the on-time or half-cycle copy
	always_comb
	begin
		cs_n         = (cfg.chip_select_half_cycle ? ~cs_h_q : ~cs_q) ? `ANFT_CS_IDLE
			: csel_q; // RL8
		addr_valid_n = cfg.addr_valid_half_cycle ? ~adv_h_q : ~adv_q; // RL10
		oe_n         = cfg.output_enable_half_cycle ? ~oe_h_q : ~oe_q; // RL11
		we_n         = cfg.write_strobe_half_cycle ? ~we_h_q : ~we_q; // RL13
	end

	// Remaining outputs come straight from flops, req_ready from a decode of state_q; clock is never output
	assign req_ready   = (state_q == anft_pkg::ANFT_IDLE); // RL18
	assign rdata_valid = rv_q;
	assign rdata       = rd_q;
	assign done        = done_q;
	assign be_n        = be_q; // RL7
	assign addr_out    = addr_q;
	assign ad_out      = ad_q;
	assign ad_oe       = drv_q;
	assign wait_sel    = ws_q;
endmodule

// ===== pkg/anft_map.svh
// Purpose: Constants for the asynchronous NOR flash timing engine.
// Assumes: Timing fields are counts of functional-clock cycles.
// Notes: Functional notes below list the behaviour of the engine.
// Functional notes
// RL1: Single read samples data after access-time count times (scale+1) cycles.
// RL2: Page read samples first word after scaled access-time count.
// RL3: Each later page word sampled one scaled page interval after previous.
// RL4: Each later page word address phase lasts one scaled page interval.
// RL5: Chip select low from assert time to read or write release, scaled.
// RL6: Page burst of n words lengthens chip select by (n-1) scaled intervals.
// RL7: Byte enables valid for scaled cycle length plus (n-1) page intervals.
// RL8: Chip select asserts at scaled assert time, plus optional half cycle.
// RL9: Address and byte enables driven from access start, before chip select.
// RL10: Address-valid asserted and released at scaled times, optional half cycle.
// RL11: Output enable asserted and released at scaled times, optional half cycle.
// RL12: Burst output enable release extended by (n-1) scaled page intervals.
// RL13: Write strobe asserted and released at scaled times, optional half cycle.
// RL14: Write data driven on the bus from access start.
// RL15: Address held invalid for scaled inter-access gap between accesses.
// RL16: Multiplexed read ends address phase at output enable, then releases bus.
// RL17: Bus direction control stays internal, never on a pin.
// RL18: All timing runs from the internal functional clock, not output.
// RL19: Eight active-low chip selects and two wait inputs, chosen per region.
// RL20: Flash presents read data within the programmed access-time count.
// RL21: All counts except the inter-access gap measured from the access start edge, counted as zero.
// RL22: Scale setting is a single bit, multiplying counts by one or two.
`ifndef ANFT_MAP_SVH
`define ANFT_MAP_SVH
`define ANFT_TW        6
`define ANFT_CW        10
`define ANFT_CNT_ZERO  10'h000
`define ANFT_CNT_ONE   10'h001
`define ANFT_WORD_ZERO 3'h0
`define ANFT_WORD_ONE  3'h1
`define ANFT_DATA_ZERO 16'h0000
`define ANFT_ADDR_ZERO 26'h0000000
`define ANFT_CS_IDLE   8'hff
`define ANFT_BE_IDLE   2'h3
`endif

// ===== pkg/anft_pkg.sv
// Purpose: Types for the asynchronous NOR flash timing engine.
// Assumes: Widths follow the constants header.
// Notes: Timing set and request travel as packed structs.
package anft_pkg;
	typedef struct packed {
		logic [5:0] chip_select_assert_time;
		logic [5:0] chip_select_read_release;
		logic [5:0] chip_select_write_release;
		logic [5:0] addr_valid_assert_time;
		logic [5:0] addr_valid_read_release;
		logic [5:0] addr_valid_write_release;
		logic [5:0] output_enable_assert_time;
		logic [5:0] output_enable_release_time;
		logic [5:0] write_strobe_assert_time;
		logic [5:0] write_strobe_release_time;
		logic [5:0] read_cycle_length;
		logic [5:0] write_cycle_length;
		logic [5:0] data_sample_delay;
		logic [5:0] page_word_interval;
		logic [5:0] inter_access_gap;
		logic       timing_scale_bit;
		logic       chip_select_half_cycle;
		logic       addr_valid_half_cycle;
		logic       output_enable_half_cycle;
		logic       write_strobe_half_cycle;
		logic       muxed_mode;
	} anft_timing_t;

	typedef struct packed {
		logic        write;
		logic [2:0]  region;
		logic [2:0]  words_m1;
		logic [25:0] addr;
		logic [1:0]  byte_en_n;
		logic [15:0] wdata;
	} anft_req_t;

	typedef enum logic [1:0] {
		ANFT_IDLE = 2'b00,
		ANFT_ACC  = 2'b01,
		ANFT_GAP  = 2'b11
	} anft_state_t;
endpackage

// ===== sim/anft_ctrl_checker.sv
// Purpose: Port-level timing checks for the NOR flash access engine.
// Assumes: Chip-select half-cycle delay off whenever chip select width is judged.
// Notes: Attached to every engine instance by bind.
`timescale 1ns/1ps
module anft_ctrl_checker #(
	parameter int NUM_CS = 8
) (
	input wire logic                   ref_clk,     // Clock
	input wire logic                   rst_n,       // Reset
	input wire anft_pkg::anft_timing_t cfg,         // Timing set
	input wire logic                   req_valid,   // Request
	input wire anft_pkg::anft_req_t    req,         // Request fields
	input wire logic                   req_ready,   // Idle
	input wire logic                   rdata_valid, // Read strobe
	input wire logic                   done,        // End pulse
	input wire logic [NUM_CS-1:0]      cs_n,        // Chip selects
	input wire logic                   oe_n,        // Output enable
	input wire logic                   we_n,        // Write strobe
	input wire logic [1:0]             be_n,        // Byte enables
	input wire logic [25:0]            addr_out,    // Address
	input wire logic [15:0]            ad_out,      // Bus out
	input wire logic                   ad_oe        // Bus drive
);
	anft_pkg::anft_req_t r_q;
	logic [9:0]          low_q;
	logic [9:0]          cs_len;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	// Remember the taken request and count chip-select low cycles
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			r_q <= '0;
			low_q <= 10'h000;
		end
		else
		begin
			if (req_valid && req_ready)
				r_q <= req;
			low_q <= (&cs_n) ? 10'h000 : low_q + 10'h001;
		end
	end
	// Expected low span of chip select for the remembered access
	assign cs_len = 10'((r_q.write ? cfg.chip_select_write_release : cfg.chip_select_read_release)
		- cfg.chip_select_assert_time + r_q.words_m1 * cfg.page_word_interval) << cfg.timing_scale_bit;
	sequence s_take;
		req_valid && req_ready;
	endsequence
	sequence s_cs_start;
		$fell(&cs_n);
	endsequence
	chk_cs_onehot: assert property ($countones(~cs_n) <= 1) else $error("two chip selects low");
	chk_cs_region: assert property (!(&cs_n) |-> !cs_n[r_q.region]) else $error("wrong chip select");
	chk_take_busy: assert property (s_take |=> !req_ready) else $error("ready after take");
	chk_done_pulse: assert property (done |=> !done) else $error("done too long");
	chk_read_word: assert property (rdata_valid |-> !r_q.write) else $error("word on write");
	chk_read_strobe: assert property (!r_q.write |-> we_n) else $error("write strobe on read");
	chk_write_oe: assert property (r_q.write |-> oe_n) else $error("output enable on write");
	chk_addr_early: assert property (s_cs_start |-> addr_out == r_q.addr && be_n == r_q.byte_en_n)
		else $error("address late");
	chk_wdata_early: assert property (s_cs_start ##0 (r_q.write && !cfg.muxed_mode)
		|-> ad_oe && ad_out == r_q.wdata) else $error("write data late");
	chk_bus_turn: assert property (!oe_n |-> !ad_oe) else $error("bus driven on read");
	chk_cs_width: assert property ($rose(&cs_n) && !cfg.chip_select_half_cycle |-> low_q == cs_len)
		else $error("chip select width");
endmodule
bind anft_ctrl anft_ctrl_checker #(.NUM_CS(NUM_CS)) anft_ctrl_checker_i (.ref_clk, .rst_n, .cfg,
	.req_valid, .req, .req_ready, .rdata_valid, .done, .cs_n, .oe_n, .we_n, .be_n, .addr_out,
	.ad_out, .ad_oe);

// ===== sim/anft_ctrl_tb.sv
// Purpose: Directed accesses through the NOR flash timing engine.
// Assumes: Strobe spans are counted at falling edges, away from updates.
// Notes: Read words carry the flash model's time stamp.
`timescale 1ns/1ps
module anft_ctrl_tb;
	localparam int CSON = 1, CSR = 9, CSW = 8, OEON = 3, OEOF = 9, WEON = 2, WEOF = 6;
	localparam int RDC = 10, WRC = 9, ACC = 7, PIW = 2, ADVON = 1, ADVR = 3, ADVW = 3, GAP = 2;
	localparam logic [1:0] WIN = 2'h1;
	logic                   ref_clk, rst_n, req_valid, req_ready, rdata_valid, done;
	logic                   addr_valid_n, oe_n, we_n, ad_oe, wait_sel;
	anft_pkg::anft_timing_t cfg;
	anft_pkg::anft_req_t    req;
	logic [7:0]             cs_n;
	logic [1:0]             be_n;
	logic [15:0]            rdata, ad_out, ad_in;
	logic [25:0]            addr_out;
	int                     fail_count, cmp_count;
	anft_ctrl anft_ctrl_i (.ref_clk, .rst_n, .cfg, .req_valid, .req, .req_ready, .rdata_valid,
		.rdata, .done, .cs_n, .addr_valid_n, .oe_n, .we_n, .be_n, .addr_out, .ad_out, .ad_oe,
		.ad_in, .wait_in(WIN), .wait_sel);
	anft_flash_model anft_flash_model_i (.ref_clk, .rst_n, .cs_n, .oe_n, .ad_oe, .ad_out,
		.ad_in);
	// Compare one value and count it
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("BAD %s exp %h seen %h", what, exp, seen);
		end
	endtask
	task automatic final_report;
		$display("comparisons %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// One access: request, then measure strobe spans until done
	task automatic access(input logic w, input logic [2:0] rg, input logic [2:0] nm1,
		input logic g, input logic mx);
		int n, s, cs_at, oe_at, we_at, cs_w, oe_w, we_w, be_w, adv_w;
		logic [15:0] wd[$];
		{cs_at, oe_at, we_at, cs_w, oe_w, we_w, be_w, adv_w} = '0;
		s = g + 1;
		@(posedge ref_clk);
		cfg.timing_scale_bit <= g;
		cfg.muxed_mode <= mx;
		req <= '{w, rg, nm1, 26'h0001230, 2'h0, 16'hc3a5};
		req_valid <= 1'b1;
		for (n = 0; n < 300; n++)
		begin
			@(posedge ref_clk);
			if (req_ready === 1'b1)
				break;
		end
		req_valid <= 1'b0;
		for (n = 1; n < 300 && done !== 1'b1; n++)
		begin
			@(negedge ref_clk);
			cs_at = (cs_w == 0) ? n : cs_at;
			oe_at = (oe_w == 0) ? n : oe_at;
			we_at = (we_w == 0) ? n : we_at;
			cs_w += (cs_n !== 8'hff);
			oe_w += (oe_n === 1'b0);
			we_w += (we_n === 1'b0);
			be_w += (be_n !== 2'h3);
			adv_w += (addr_valid_n === 1'b0);
			if (rdata_valid === 1'b1)
				wd.push_back(rdata);
		end
		check("cs span", 16'(cs_w), 16'(((w ? CSW : CSR) - CSON + nm1 * PIW) * s));
		check("be span", 16'(be_w), 16'(((w ? WRC : RDC) + nm1 * PIW) * s));
		check("words", 16'(wd.size()), 16'(w ? 0 : nm1 + 1));
		check("adv span", 16'(adv_w), 16'(((w ? ADVW : ADVR) - ADVON) * s));
		check("wait sel", 16'(wait_sel), 16'(WIN[rg[0]]));
		check("last addr", addr_out[15:0], 16'h1230 + 16'(w ? 0 : nm1));
		if (w)
		begin
			check("we span", 16'(we_w), 16'((WEOF - WEON) * s));
			check("we delay", 16'(we_at - cs_at), 16'((WEON - CSON) * s));
			check("oe idle", 16'(oe_w), 16'h0000);
		end
		else
		begin
			check("oe span", 16'(oe_w), 16'((OEOF + nm1 * PIW - OEON) * s));
			check("oe delay", 16'(oe_at - cs_at), 16'((OEON - CSON) * s));
			check("we idle", 16'(we_w), 16'h0000);
			check("first word", wd[0], {8'ha5, 8'((ACC - CSON) * s - 1)});
			for (n = 1; n < wd.size(); n++)
				check("page step", wd[n] - wd[n-1], 16'(PIW * s));
		end
		// Count idle cycles between the end of the access and ready again
		for (n = 0; n < 300 && req_ready !== 1'b1; n++)
			@(negedge ref_clk);
		check("gap", 16'(n), 16'(GAP * s));
		$display("access done write %0d region %0d words %0d", w, rg, nm1 + 1);
	endtask
	initial
	begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	initial
	begin
		#200000;
		fail_count++;
		final_report();
	end
	initial
	begin
		rst_n = 1'b0;
		req_valid = 1'b0;
		req = '0;
		cfg = '{6'h01, 6'h09, 6'h08, 6'h01, 6'h03, 6'h03, 6'h03, 6'h09, 6'h02, 6'h06, 6'h0a,
			6'h09, 6'h07, 6'h02, 6'h02, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
		repeat (6) @(posedge ref_clk);
		rst_n <= 1'b1;
		access(1'b0, 3'h3, 3'h0, 1'b0, 1'b0);
		access(1'b0, 3'h7, 3'h3, 1'b1, 1'b0);
		access(1'b1, 3'h0, 3'h0, 1'b0, 1'b0);
		access(1'b1, 3'h5, 3'h0, 1'b1, 1'b0);
		access(1'b0, 3'h2, 3'h1, 1'b0, 1'b1);
		access(1'b1, 3'h1, 3'h0, 1'b0, 1'b1);
		final_report();
	end
endmodule

// ===== sim/anft_flash_model.sv
// Purpose: Behavioural far-side flash for the NOR timing engine.
// Assumes: Read word carries a count of selected cycles as a time stamp.
// Notes: Idle bus shows a pattern that flips every cycle.
`timescale 1ns/1ps
module anft_flash_model (
	input  wire logic        ref_clk, // Functional clock
	input  wire logic        rst_n,   // Reset, active low
	input  wire logic [7:0]  cs_n,    // Chip selects
	input  wire logic        oe_n,    // Output enable
	input  wire logic        ad_oe,   // Controller drives bus
	input  wire logic [15:0] ad_out,  // Controller bus value
	output logic      [15:0] ad_in    // Resolved bus level
);
	logic [7:0] age_q;
	logic       tog_q;
	// Count selected cycles so the sampled word tells when it was taken
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			age_q <= 8'h00;
			tog_q <= 1'b0;
		end
		else
		begin
			age_q <= (&cs_n) ? 8'h00 : age_q + 8'h01;
			tog_q <= ~tog_q;
		end
	end
	// Controller drive wins; flash drives only while selected and output enabled; else a flipping pattern
	assign ad_in = ad_oe ? ad_out
		: (!(&cs_n) && !oe_n) ? {8'ha5, age_q}
		: {16{tog_q}} ^ 16'h5a5a;
endmodule
